/* hw/pcgu_pkg.sv */
// Purpose: constants, offsets and helpers of the pulse command gear unit
// Assumes: 32-bit APB data, one aligned word per register
// Notes: quadrature helper is shared by command and encoder decoders
package pcgu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PPR = 8'h04;
  localparam logic [7:0] OFS_NUM1 = 8'h08;
  localparam logic [7:0] OFS_NUM2 = 8'h0C;
  localparam logic [7:0] OFS_NUM3 = 8'h10;
  localparam logic [7:0] OFS_NUM4 = 8'h14;
  localparam logic [7:0] OFS_DEN = 8'h18;
  localparam logic [7:0] OFS_DIVNUM = 8'h1C;
  localparam logic [7:0] OFS_DIVDEN = 8'h20;
  localparam logic [7:0] OFS_TORQ = 8'h24;
  localparam logic [7:0] OFS_OVF = 8'h28;
  localparam logic [7:0] OFS_STAT = 8'h2C;
  localparam logic [7:0] OFS_ERR = 8'h30;
  localparam logic [7:0] OFS_TGT = 8'h34;
  // control field positions
  localparam int CTRL_SEL = 0;
  localparam int CTRL_INV = 1;
  localparam int CTRL_MTH = 2;
  localparam int CTRL_PHB = 4;
  localparam int CTRL_CLR = 8;
  // reset values
  localparam logic [1:0] RST_METHOD = 2'h1;
  localparam logic [20:0] RST_PPR = 21'h002710;
  localparam logic [30:0] RST_NUM = 31'h00000000;
  localparam logic [30:0] RST_DEN = 31'h00002710;
  localparam logic [18:0] RST_DIVNUM = 19'h009C4;
  localparam logic [30:0] RST_DIVDEN = 31'h00000000;
  localparam logic [8:0] RST_TORQ = 9'h1F4;
  localparam logic [8:0] TORQ_MAX = 9'h1F4;
  localparam logic [27:0] RST_OVF = 28'h00186A0;
  // counting methods
  typedef enum logic [1:0] {
    M_QUAD_A = 2'h0,
    M_CW_CCW = 2'h1,
    M_QUAD_B = 2'h2,
    M_PLS_DIR = 2'h3
  } pcgu_method_type;

  // {step, reverse} from two samples of a quadrature pair
  function automatic logic [1:0] quad_step(input logic [1:0] prv, input logic [1:0] cur);
    logic one_bit;
    one_bit = (prv[0] ^ cur[0]) ^ (prv[1] ^ cur[1]);
    return {one_bit, one_bit & ~(prv[1] ^ cur[0])};
  endfunction : quad_step
endpackage : pcgu_pkg

/* hw/pcgu_enc_if.sv */
// Purpose: carrier between top and encoder divider
// Assumes: single clock domain
// Notes: top drives steps and settings, divider drives phases
`timescale 1ns/1ps
interface pcgu_enc_if;
  logic step;
  logic rev;
  logic [18:0] div_num;
  logic [30:0] div_den;
  logic [1:0] phb_sel;
  logic out_a;
  logic out_b;
  modport top (output step, rev, div_num, div_den, phb_sel, input out_a, out_b);
  modport div (input step, rev, div_num, div_den, phb_sel, output out_a, out_b);
endinterface : pcgu_enc_if

/* hw/pcgu_enc_div.sv */
// Purpose: divides encoder steps into a quadrature pulse output
// Assumes: encoder steps arrive at most one per clock
// Notes: remainder accumulator, one output step per clock at most
`timescale 1ns/1ps
module pcgu_enc_div #(
  parameter logic [30:0] ENC_RES = 31'h00020000
) (
  input wire logic pclk,
  input wire logic presetn,
  pcgu_enc_if.div eif
);
  logic signed [33:0] acc_ff;
  logic [1:0] st_ff;
  logic a_ff;
  logic b_ff;
  logic signed [33:0] den;
  logic signed [33:0] add;
  logic fwd;
  logic bwd;

  // denominator falls back to encoder resolution when zero
  always_comb begin
    den = $signed({3'h0, (eif.div_den == 31'h0) ? ENC_RES : eif.div_den});
    add = eif.step ? (eif.rev ? -$signed({15'h0, eif.div_num}) : $signed({15'h0, eif.div_num}))
                   : 34'sh0;
    fwd = acc_ff >= den;
    bwd = acc_ff <= -den;
  end

  // remainder accumulator and output phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 34'sh0;
      st_ff <= 2'h0;
    end else begin
      acc_ff <= acc_ff + add - (fwd ? den : 34'sh0) + (bwd ? den : 34'sh0);
      if (fwd) begin
        st_ff <= st_ff + 2'h1;
      end else if (bwd) begin
        st_ff <= st_ff - 2'h1;
      end
    end
  end

  // registered phases, phase b optionally inverted, codes 2 and 3 plain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
    end else begin
      a_ff <= st_ff[1];
      b_ff <= (st_ff[1] ^ st_ff[0]) ^ (eif.phb_sel == 2'h1);
    end
  end
  assign eif.out_a = a_ff;
  assign eif.out_b = b_ff;

  phase_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 b_ff == ($past(st_ff[1] ^ st_ff[0]) ^ ($past(eif.phb_sel) == 2'h1)))
    else $error("phase b polarity wrong");
  div_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff != $past(st_ff)) |-> $past(fwd | bwd))
    else $error("divider stepped without carry");
  div_cov_c: cover property (@(posedge pclk) disable iff (!presetn) fwd ##1 fwd);
endmodule : pcgu_enc_div

/* hw/pcgu_top.sv */
// Purpose: command pulse decode, electronic gear, error watch, encoder divide
// Assumes: pins synchronous to pclk, APB slave with zero wait states
// Notes: gear output is one encoder unit per clock from a remainder
// Functional notes
// - select pulse/sign pair or line-driver pair
// - optionally reverse direction of every command pulse
// - four counting methods, default code one
// - nonzero pulses-per-rev sets pulses per revolution
// - zero pulses-per-rev uses numerator over denominator
// - two gear-select inputs choose one of four numerators
// - gear ratio multiplies command pulses
// - encoder output divided by numerator over denominator, resolution when zero
// - encoder sourced output, phase b polarity selectable
// - torque limit percent, 0 to 500, default 500
// - hold overflow level, compare error against it
`timescale 1ns/1ps
module pcgu_top #(
  parameter logic [30:0] ENC_RES = 31'h00020000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_input_pair,
  input wire logic sign_input_pair,
  input wire logic cw_line_input,
  input wire logic ccw_line_input,
  input wire logic gear_select_bit0,
  input wire logic gear_select_bit1,
  input wire logic enc_a,
  input wire logic enc_b,
  output logic enc_out_a,
  output logic enc_out_b,
  output logic [8:0] first_torque_limit,
  output logic overflow_alarm
);
  pcgu_enc_if eif ();

  logic pulse_input_select_ff;
  logic pulse_direction_invert_ff;
  logic [1:0] pulse_count_method_ff;
  logic [1:0] encoder_out_phase_b_invert_ff;
  logic [20:0] gear_pulses_per_rev_ff;
  logic [30:0] gear_num_ff [4];
  logic [30:0] gear_denominator_ff;
  logic [18:0] divider_numerator_ff;
  logic [30:0] divider_denominator_ff;
  logic [8:0] torque_ff;
  logic [27:0] position_error_overflow_level_ff;
  logic [31:0] prdata_ff;
  logic slverr_ff;
  logic [1:0] cmd_prev_ff;
  logic [1:0] enc_prev_ff;
  logic signed [39:0] pending_ff;
  logic signed [31:0] target_ff;
  logic signed [31:0] enc_pos_ff;
  logic alarm_ff;
  logic [1:0] cmd_raw;
  logic [1:0] cmd_q;
  logic [1:0] enc_q;
  logic raw_step;
  logic raw_rev;
  logic cmd_step;
  logic cmd_rev;
  logic [1:0] num_idx;
  logic [30:0] eff_num;
  logic [30:0] eff_den;
  logic signed [39:0] sden;
  logic signed [39:0] add;
  logic g_up;
  logic g_dn;
  logic signed [31:0] pos_err;
  logic [31:0] err_mag;
  logic over;
  logic wr_en;
  logic rd_setup;
  logic clr_req;
  logic mapped;
  logic [31:0] rd_val;

  // address decode, true for every implemented offset
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= pcgu_pkg::OFS_TGT);
  endfunction : is_mapped

  // magnitude of a signed error
  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : mag

  // apb strobes: write at access edge, read data latched at setup
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = is_mapped(paddr);
  assign clr_req = wr_en && (paddr == pcgu_pkg::OFS_CTRL) && pwdata[pcgu_pkg::CTRL_CLR];
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = slverr_ff & psel & penable;

  // control register and gear settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_input_select_ff <= 1'b0;
      pulse_direction_invert_ff <= 1'b0;
      pulse_count_method_ff <= pcgu_pkg::RST_METHOD;
      encoder_out_phase_b_invert_ff <= 2'h0;
      gear_pulses_per_rev_ff <= pcgu_pkg::RST_PPR;
      gear_denominator_ff <= pcgu_pkg::RST_DEN;
      for (int i = 0; i < 4; i++) begin
        gear_num_ff[i] <= pcgu_pkg::RST_NUM;
      end
    end else if (wr_en) begin
      case (paddr)
        pcgu_pkg::OFS_CTRL: begin
          pulse_input_select_ff <= pwdata[pcgu_pkg::CTRL_SEL];
          pulse_direction_invert_ff <= pwdata[pcgu_pkg::CTRL_INV];
          pulse_count_method_ff <= pwdata[pcgu_pkg::CTRL_MTH +: 2];
          encoder_out_phase_b_invert_ff <= pwdata[pcgu_pkg::CTRL_PHB +: 2];
        end
        pcgu_pkg::OFS_PPR: gear_pulses_per_rev_ff <= pwdata[20:0];
        pcgu_pkg::OFS_NUM1: gear_num_ff[0] <= pwdata[30:0];
        pcgu_pkg::OFS_NUM2: gear_num_ff[1] <= pwdata[30:0];
        pcgu_pkg::OFS_NUM3: gear_num_ff[2] <= pwdata[30:0];
        pcgu_pkg::OFS_NUM4: gear_num_ff[3] <= pwdata[30:0];
        pcgu_pkg::OFS_DEN: gear_denominator_ff <= pwdata[30:0];
        default: begin
        end
      endcase
    end
  end

  // divider, torque and overflow settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_numerator_ff <= pcgu_pkg::RST_DIVNUM;
      divider_denominator_ff <= pcgu_pkg::RST_DIVDEN;
      torque_ff <= pcgu_pkg::RST_TORQ;
      position_error_overflow_level_ff <= pcgu_pkg::RST_OVF;
    end else if (wr_en) begin
      case (paddr)
        pcgu_pkg::OFS_DIVNUM: divider_numerator_ff <= pwdata[18:0];
        pcgu_pkg::OFS_DIVDEN: divider_denominator_ff <= pwdata[30:0];
        pcgu_pkg::OFS_TORQ: begin
          torque_ff <= (pwdata[31:0] > 32'(pcgu_pkg::TORQ_MAX)) ? pcgu_pkg::TORQ_MAX
                       : pwdata[8:0];
        end
        pcgu_pkg::OFS_OVF: position_error_overflow_level_ff <= pwdata[27:0];
        default: begin
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h0;
    case (paddr)
      pcgu_pkg::OFS_CTRL: begin
        rd_val = {26'h0, encoder_out_phase_b_invert_ff, pulse_count_method_ff,
                  pulse_direction_invert_ff, pulse_input_select_ff};
      end
      pcgu_pkg::OFS_PPR: rd_val = {11'h0, gear_pulses_per_rev_ff};
      pcgu_pkg::OFS_NUM1: rd_val = {1'b0, gear_num_ff[0]};
      pcgu_pkg::OFS_NUM2: rd_val = {1'b0, gear_num_ff[1]};
      pcgu_pkg::OFS_NUM3: rd_val = {1'b0, gear_num_ff[2]};
      pcgu_pkg::OFS_NUM4: rd_val = {1'b0, gear_num_ff[3]};
      pcgu_pkg::OFS_DEN: rd_val = {1'b0, gear_denominator_ff};
      pcgu_pkg::OFS_DIVNUM: rd_val = {13'h0, divider_numerator_ff};
      pcgu_pkg::OFS_DIVDEN: rd_val = {1'b0, divider_denominator_ff};
      pcgu_pkg::OFS_TORQ: rd_val = {23'h0, torque_ff};
      pcgu_pkg::OFS_OVF: rd_val = {4'h0, position_error_overflow_level_ff};
      pcgu_pkg::OFS_STAT: rd_val = {28'h0, num_idx, gear_pulses_per_rev_ff == 21'h0, alarm_ff};
      pcgu_pkg::OFS_ERR: rd_val = pos_err;
      pcgu_pkg::OFS_TGT: rd_val = target_ff;
      default: rd_val = 32'h0;
    endcase
  end

  // read data and error flag captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      slverr_ff <= 1'b0;
    end else if (psel & ~penable) begin
      prdata_ff <= rd_setup ? rd_val : 32'h0;
      slverr_ff <= ~mapped;
    end
  end

  // pin pair selection and command decode
  always_comb begin
    cmd_raw = pulse_input_select_ff ? {cw_line_input, ccw_line_input}
                                    : {pulse_input_pair, sign_input_pair};
    cmd_q = pcgu_pkg::quad_step(cmd_prev_ff, cmd_raw);
    raw_step = 1'b0;
    raw_rev = 1'b0;
    case (pcgu_pkg::pcgu_method_type'(pulse_count_method_ff))
      pcgu_pkg::M_QUAD_A, pcgu_pkg::M_QUAD_B: begin
        raw_step = cmd_q[1];
        raw_rev = cmd_q[0];
      end
      pcgu_pkg::M_CW_CCW: begin
        raw_step = (cmd_raw[1] & ~cmd_prev_ff[1]) ^ (cmd_raw[0] & ~cmd_prev_ff[0]);
        raw_rev = cmd_raw[0] & ~cmd_prev_ff[0];
      end
      pcgu_pkg::M_PLS_DIR: begin
        raw_step = cmd_raw[1] & ~cmd_prev_ff[1];
        raw_rev = cmd_raw[0];
      end
      default: begin
        raw_step = 1'b0;
        raw_rev = 1'b0;
      end
    endcase
    cmd_step = raw_step & ~alarm_ff;
    cmd_rev = raw_rev ^ pulse_direction_invert_ff;
  end

  // previous pin samples for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_prev_ff <= 2'h0;
      enc_prev_ff <= 2'h0;
    end else begin
      cmd_prev_ff <= cmd_raw;
      enc_prev_ff <= {enc_a, enc_b};
    end
  end

  // gear: numerator pick and ratio selection
  always_comb begin
    num_idx = {gear_select_bit1, gear_select_bit0};
    if (gear_pulses_per_rev_ff != 21'h0) begin
      eff_num = ENC_RES;
      eff_den = {10'h0, gear_pulses_per_rev_ff};
    end else begin
      eff_num = gear_num_ff[num_idx];
      eff_den = (gear_denominator_ff == 31'h0) ? 31'h1 : gear_denominator_ff;
    end
    sden = $signed({9'h0, eff_den});
    add = cmd_step ? (cmd_rev ? -$signed({9'h0, eff_num}) : $signed({9'h0, eff_num}))
                   : 40'sh0;
    g_up = pending_ff >= sden;
    g_dn = pending_ff <= -sden;
  end

  // remainder accumulator feeding one encoder unit per clock into target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_ff <= 40'sh0;
      target_ff <= 32'sh0;
    end else begin
      pending_ff <= pending_ff + add - (g_up ? sden : 40'sh0) + (g_dn ? sden : 40'sh0);
      if (g_up) begin
        target_ff <= target_ff + 32'sh1;
      end else if (g_dn) begin
        target_ff <= target_ff - 32'sh1;
      end
    end
  end

  // encoder feedback position
  assign enc_q = pcgu_pkg::quad_step(enc_prev_ff, {enc_a, enc_b});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_pos_ff <= 32'sh0;
    end else if (enc_q[1]) begin
      enc_pos_ff <= enc_q[0] ? enc_pos_ff - 32'sh1 : enc_pos_ff + 32'sh1;
    end
  end

  // error watch against overflow level
  assign pos_err = target_ff - enc_pos_ff;
  assign err_mag = mag(pos_err);
  assign over = err_mag > {4'h0, position_error_overflow_level_ff};

  // sticky alarm, a new overflow wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_ff <= 1'b0;
    end else if (over) begin
      alarm_ff <= 1'b1;
    end else if (clr_req) begin
      alarm_ff <= 1'b0;
    end
  end

  // encoder divider hookup
  assign eif.step = enc_q[1];
  assign eif.rev = enc_q[0];
  assign eif.div_num = divider_numerator_ff;
  assign eif.div_den = divider_denominator_ff;
  assign eif.phb_sel = encoder_out_phase_b_invert_ff;
  pcgu_enc_div #(.ENC_RES(ENC_RES)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .eif(eif)
  );
  assign enc_out_a = eif.out_a;
  assign enc_out_b = eif.out_b;
  assign first_torque_limit = torque_ff;
  assign overflow_alarm = alarm_ff;

  src_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pulse_input_select_ff && $stable(cw_line_input) && $stable(ccw_line_input)
     && $stable(pulse_input_select_ff)) |-> !raw_step)
    else $error("line pair idle yet step seen");
  dir_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_step && pulse_count_method_ff == 2'h3)
     |-> (cmd_rev == (cmd_raw[0] ^ pulse_direction_invert_ff)))
    else $error("direction not inverted as set");
  method_rst_a: assert property (@(posedge pclk)
    $rose(presetn) |-> pulse_count_method_ff == 2'h1)
    else $error("count method default wrong");
  gear_num_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gear_pulses_per_rev_ff == 21'h0)
     |-> eff_num == gear_num_ff[{gear_select_bit1, gear_select_bit0}])
    else $error("wrong numerator chosen");
  gear_ppr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gear_pulses_per_rev_ff != 21'h0) |-> (eff_num == ENC_RES
     && eff_den == {10'h0, gear_pulses_per_rev_ff}))
    else $error("per-rev gear not applied");
  gear_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    g_up |=> target_ff == $past(target_ff) + 32'sh1)
    else $error("gear carry lost");
  torque_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_torque_limit <= 9'h1F4)
    else $error("torque limit above range");
  alarm_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    over |=> overflow_alarm)
    else $error("overflow did not alarm");
  alarm_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (overflow_alarm && !clr_req) |=> overflow_alarm ##0 (add == 40'sh0))
    else $error("alarm dropped or command followed");
  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) |=> (psel && penable) |-> pslverr)
    else $error("unmapped access not flagged");
  cmd_cov_c: cover property (@(posedge pclk) disable iff (!presetn) cmd_step ##1 g_up);
  alarm_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    overflow_alarm ##1 clr_req ##1 !overflow_alarm);
  ratio_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    cmd_step && gear_pulses_per_rev_ff == 21'h0 && num_idx == 2'h3);
endmodule : pcgu_top

/* sim/pcgu_host_model.sv */
// Purpose: host position controller driving command pulse trains
// Assumes: pins change just after a rising pclk edge
// Notes: the idle pair toggles so that ignored inputs really move
`timescale 1ns/1ps
module pcgu_host_model (
  input wire logic pclk,
  output logic pulse_input_pair,
  output logic sign_input_pair,
  output logic cw_line_input,
  output logic ccw_line_input
);
  logic [1:0] g = 2'h0;
  initial begin
    {pulse_input_pair, sign_input_pair, cw_line_input, ccw_line_input} = 4'h0;
  end
  // one pattern on the chosen pair, noise on the other
  task automatic put(input logic sel, input logic [1:0] v);
    @(posedge pclk);
    if (sel) begin
      {cw_line_input, ccw_line_input} <= v;
      {pulse_input_pair, sign_input_pair} <= ~{pulse_input_pair, sign_input_pair};
    end else begin
      {pulse_input_pair, sign_input_pair} <= v;
      {cw_line_input, ccw_line_input} <= ~{cw_line_input, ccw_line_input};
    end
  endtask : put
  // n pulses in the pattern of the chosen counting method
  task automatic send(input logic [1:0] mth, input logic sel, input logic rev, input int n);
    for (int i = 0; i < n; i++) begin
      if (!mth[0]) begin // quadrature, one edge per pulse
        g = rev ? {~g[0], g[1]} : {g[0], ~g[1]};
        put(sel, g);
        put(sel, g);
      end else if (mth == 2'h1) begin // rise on forward or reverse line
        put(sel, rev ? 2'h1 : 2'h2);
        put(sel, 2'h0);
      end else begin // direction level set ahead of the pulse
        put(sel, {1'b0, rev});
        put(sel, {1'b1, rev});
        put(sel, {1'b0, rev});
      end
    end
    @(posedge pclk);
    {pulse_input_pair, sign_input_pair, cw_line_input, ccw_line_input} <= 4'h0;
    g = 2'h0; // quadrature state follows the pins back to idle
  endtask : send
endmodule : pcgu_host_model

/* sim/pcgu_top_tb.sv */
// Purpose: self-checking bench of the pulse command gear unit
// Assumes: encoder resolution shortened to 4 counts
// Notes: target and error are tracked here from the set ratios
`timescale 1ns/1ps
module pcgu_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pls, sgn, cwl, ccwl;
  logic gsel0 = 1'b0;
  logic gsel1 = 1'b0;
  logic enc_a = 1'b0;
  logic enc_b = 1'b0;
  logic oa, ob;
  logic [8:0] trq;
  logic alarm;
  logic [31:0] rd;
  logic er;
  logic [1:0] out_last = 2'h0;
  int n_out = 0;
  int n_errors = 0;
  int n_tests = 0;
  int enc_pos = 0;
  int exp_tgt = 0;

  pcgu_host_model u_host (.pclk(pclk), .pulse_input_pair(pls), .sign_input_pair(sgn),
    .cw_line_input(cwl), .ccw_line_input(ccwl));
  pcgu_top #(.ENC_RES(31'h00000004)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_input_pair(pls), .sign_input_pair(sgn), .cw_line_input(cwl),
    .ccw_line_input(ccwl), .gear_select_bit0(gsel0), .gear_select_bit1(gsel1),
    .enc_a(enc_a), .enc_b(enc_b), .enc_out_a(oa), .enc_out_b(ob),
    .first_torque_limit(trq), .overflow_alarm(alarm));

  // free running clock
  always #5 pclk = ~pclk;

  // counts phase changes of the divided encoder output
  always @(posedge pclk) begin
    if ({oa, ob} !== out_last) n_out <= n_out + 1;
    out_last <= {oa, ob};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, waits for pready; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask : waitc

  // encoder quadrature steps, two clocks apart
  task automatic enc_step(input logic rev, input int n);
    repeat (n) begin
      @(posedge pclk);
      {enc_a, enc_b} <= rev ? {~enc_b, enc_a} : {enc_b, ~enc_a};
      @(posedge pclk);
    end
    enc_pos += rev ? -n : n;
  endtask : enc_step

  task automatic t_reset;
    logic [7:0] ofs [8] = '{pcgu_pkg::OFS_CTRL, pcgu_pkg::OFS_PPR, pcgu_pkg::OFS_NUM1,
      pcgu_pkg::OFS_DEN, pcgu_pkg::OFS_DIVNUM, pcgu_pkg::OFS_DIVDEN, pcgu_pkg::OFS_TORQ,
      pcgu_pkg::OFS_OVF};
    logic [31:0] ev [8] = '{32'h4, 32'h2710, 32'h0, 32'h2710, 32'h9C4, 32'h0, 32'h1F4,
      32'h186A0};
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, ev[i]);
    end
    chk({23'h0, trq}, 32'h1F4);
    chk({31'h0, alarm}, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h25, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, pcgu_pkg::OFS_STAT, 32'hFFFFFFFF);
    apb(1'b0, pcgu_pkg::OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, pcgu_pkg::OFS_TORQ, 32'h258);
    apb(1'b0, pcgu_pkg::OFS_TORQ, 32'h0);
    chk(rd, 32'h1F4);
    apb(1'b1, pcgu_pkg::OFS_TORQ, 32'h64);
    waitc(1);
    chk({23'h0, trq}, 32'h64);
    $display("test reset done");
  endtask : t_reset

  // every method, both input pairs, both direction settings
  task automatic t_methods;
    logic eff;
    apb(1'b1, pcgu_pkg::OFS_PPR, 32'h2); // ratio 4/2 kept in range
    for (int k = 0; k < 16; k++) begin
      eff = k[1];
      apb(1'b1, pcgu_pkg::OFS_CTRL, {28'h0, k[3:2], k[0], k[1]});
      u_host.send(k[3:2], k[1], k[1] ^ k[0], 4);
      waitc(40);
      exp_tgt += eff ? -8 : 8;
      apb(1'b0, pcgu_pkg::OFS_TGT, 32'h0);
      chk(rd, exp_tgt);
    end
    $display("test methods done");
  endtask : t_methods

  // numerator chosen by the select inputs over a shared denominator
  task automatic t_gear;
    apb(1'b1, pcgu_pkg::OFS_PPR, 32'h0);
    apb(1'b1, pcgu_pkg::OFS_DEN, 32'h2);
    apb(1'b1, pcgu_pkg::OFS_CTRL, 32'hC);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, pcgu_pkg::OFS_NUM1 + 8'(4 * i), 32'(4 * i + 2));
    end
    for (int i = 0; i < 4; i++) begin
      {gsel1, gsel0} <= i[1:0];
      u_host.send(2'h3, 1'b0, 1'b0, 4);
      waitc(40);
      exp_tgt += 8 * i + 4;
      apb(1'b0, pcgu_pkg::OFS_TGT, 32'h0);
      chk(rd, exp_tgt);
      apb(1'b0, pcgu_pkg::OFS_STAT, 32'h0);
      chk(rd, {28'h0, i[1:0], 2'h2});
    end
    $display("test gear done");
  endtask : t_gear

  // divide by 2 over resolution 4, then phase b codes
  task automatic t_encdiv;
    int n0;
    apb(1'b1, pcgu_pkg::OFS_DIVNUM, 32'h2);
    n0 = n_out;
    enc_step(1'b0, 8);
    waitc(10);
    chk(n_out - n0, 32'h4);
    chk({30'h0, oa, ob}, 32'h0);
    enc_step(1'b0, 2);
    waitc(10);
    chk({30'h0, oa, ob}, 32'h1);
    apb(1'b1, pcgu_pkg::OFS_CTRL, 32'h1C);
    waitc(3);
    chk({30'h0, oa, ob}, 32'h0);
    apb(1'b1, pcgu_pkg::OFS_CTRL, 32'h2C);
    waitc(3);
    chk({30'h0, oa, ob}, 32'h1);
    enc_step(1'b1, 2);
    waitc(10);
    chk({30'h0, oa, ob}, 32'h0);
    $display("test encoder divider done");
  endtask : t_encdiv

  // level boundary, alarm blocks commands, clear resumes
  task automatic t_alarm;
    apb(1'b1, pcgu_pkg::OFS_OVF, 32'd63);
    u_host.send(2'h3, 1'b0, 1'b0, 1);
    waitc(20);
    exp_tgt += 7;
    chk({31'h0, alarm}, 32'h0);
    apb(1'b0, pcgu_pkg::OFS_ERR, 32'h0);
    chk(rd, exp_tgt - enc_pos);
    apb(1'b1, pcgu_pkg::OFS_OVF, 32'd62);
    waitc(3);
    chk({31'h0, alarm}, 32'h1);
    u_host.send(2'h3, 1'b0, 1'b0, 4);
    waitc(40);
    apb(1'b0, pcgu_pkg::OFS_TGT, 32'h0);
    chk(rd, exp_tgt);
    apb(1'b1, pcgu_pkg::OFS_OVF, 32'd1000);
    apb(1'b1, pcgu_pkg::OFS_CTRL, 32'h10C);
    waitc(2);
    chk({31'h0, alarm}, 32'h0);
    u_host.send(2'h3, 1'b0, 1'b0, 1);
    waitc(20);
    exp_tgt += 7;
    apb(1'b0, pcgu_pkg::OFS_TGT, 32'h0);
    chk(rd, exp_tgt);
    $display("test alarm done");
  endtask : t_alarm

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_methods();
    t_gear();
    t_encdiv();
    t_alarm();
    end_of_test();
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule : pcgu_top_tb
